// ### common/cwrd_params.svh
// constants for the configuration word reset decoder
`ifndef CWRD_PARAMS_SVH
`define CWRD_PARAMS_SVH
// register byte addresses, each the word index times four
`define CWRD_WDOG_CTRL_IDX 8'h30
`define CWRD_BOR_CTRL_IDX 8'h3f
`define CWRD_CFG_WORD_IDX 8'h40
`define CWRD_STATUS_IDX 8'h41
`define CWRD_WDOG_CTRL_ADDR 10'h0c0
`define CWRD_BOR_CTRL_ADDR 10'h0fc
`define CWRD_CFG_WORD_ADDR 10'h100
`define CWRD_STATUS_ADDR 10'h104
// configuration word field positions
`define CWRD_PROT_POS 7
`define CWRD_PUP_POS 5
`define CWRD_WDOG_HI 4
`define CWRD_WDOG_LO 3
`define CWRD_BROWN_HI 2
`define CWRD_BROWN_LO 1
`define CWRD_CLKSEL_POS 0
// software enable bits
`define CWRD_WDOG_SOFT_POS 0
`define CWRD_BROWN_SOFT_POS 7
// reset values
`define CWRD_WDOG_CTRL_RST 8'h00
`define CWRD_BOR_CTRL_RST 8'h80
`define CWRD_CFG_RST 14'h3fff
`endif

// ### common/cwrd_pkg.sv
// types for the configuration word reset decoder
package cwrd_pkg;
  // two-bit enable policy of the watchdog and brown-out fields
  typedef enum logic [1:0] {
    CWRD_POL_OFF = 2'h0,
    CWRD_POL_SOFT = 2'h1,
    CWRD_POL_RUN = 2'h2,
    CWRD_POL_ON = 2'h3
  } cwrd_policy_t;
  // decoded, latched configuration
  typedef struct packed {
    logic code_protect;
    logic powerup_timer_en;
    cwrd_policy_t watchdog_enable_field;
    cwrd_policy_t brownout_enable_field;
    logic external_clock_mode;
  } cwrd_cfg_t;
  // effective enables driven out
  typedef struct packed {
    logic powerup_timer;
    logic watchdog_timer;
    logic brownout_reset;
    logic external_clock_mode;
    logic clock_in_pin_gpio;
    logic code_protect;
  } cwrd_en_t;
endpackage : cwrd_pkg

// ### core/cwrd_policy.sv
// one enable policy decoder, shared by watchdog and brown-out
`timescale 1ns/10ps
`default_nettype none
module cwrd_policy
  import cwrd_pkg::*;
(
  // policy and conditions
  input wire cwrd_policy_t policy_in,
  input wire logic sleep_in,
  input wire logic soft_en_in,
  // decoded enable
  output logic enable_out
);
  // combinational decode of the two-bit field
  always_comb begin
    case (policy_in)
      CWRD_POL_ON: enable_out = 1'b1; // R2 R5
      CWRD_POL_RUN: enable_out = ~sleep_in; // R3 R6
      CWRD_POL_SOFT: enable_out = soft_en_in; // R4 R7
      default: enable_out = 1'b0; // R2 R5
    endcase
  end
endmodule : cwrd_policy
`default_nettype wire

// ### core/cwrd_sync.sv
// three-stage synchroniser for an asynchronous level
`timescale 1ns/10ps
`default_nettype none
module cwrd_sync (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // async level and its clean copy
  input wire logic async_in,
  output logic level_out
);
  logic s1_r; // first stage, read by s2 only
  logic s2_r;
  logic s3_r;
  // shift chain; level changes once s2 and s3 agree
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule : cwrd_sync
`default_nettype wire

// ### core/cwrd_top.sv
// configuration word decoder driving reset and power enables
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cwrd_params.svh"
////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1 - power-up timer on when its bit is 0
// R2 - watchdog field 11 on, 00 off
// R3 - watchdog field 10 runs, stops in sleep
// R4 - watchdog field 01 follows software enable
// R5 - brown-out 11 on, 00 off, software ignored
// R6 - brown-out 10 on running, off sleeping
// R7 - brown-out 01 follows software enable bit
// R8 - clock select 1 external, 0 internal
// R9 - power-up timer independent of brown-out
// R10 - code protect cleared only by bulk erase; here reset also clears it
// R11 - latch config at reset release, hold
module cwrd_top
  import cwrd_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // nonvolatile word and core status
  input wire logic [13:0] cfg_word_in,
  input wire logic sleep_in,
  input wire logic bulk_erase_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // effective enables
  output var cwrd_en_t en_out
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] wdog_ctrl_r; // soft watchdog enable in bit 0
  logic [7:0] bor_ctrl_r; // soft brownout enable in bit 7
  logic [13:0] cfg_word_r; // snapshot of the word
  cwrd_cfg_t cfg_r; // decoded snapshot
  logic cfg_loaded_r; // snapshot taken since reset
  logic cp_latch_r; // sticky code protection
  logic sleep_s; // synchronised sleep
  logic erase_s; // synchronised bulk erase
  logic erase_d_r; // erase edge helper
  logic wdog_en_w;
  logic bor_en_w;
  logic wb_req_w;
  logic [31:0] rd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, sleep and erase come from other domains
  cwrd_sync u_sync_sleep (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .async_in(sleep_in),
    .level_out(sleep_s)
  );
  cwrd_sync u_sync_erase (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .async_in(bulk_erase_in),
    .level_out(erase_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration snapshot, taken by the clock after reset release
  // reset loads a constant only; the word is captured on the first edge
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_word_r <= `CWRD_CFG_RST;
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_word_r <= cfg_word_in; // R11
      cfg_loaded_r <= 1'b1; // R11
    end
  end

  // decode of the held word; fixed until the next reset
  always_comb begin
    cfg_r.code_protect = ~cfg_word_r[`CWRD_PROT_POS];
    cfg_r.powerup_timer_en = ~cfg_word_r[`CWRD_PUP_POS]; // R1 R9
    cfg_r.watchdog_enable_field =
      cwrd_policy_t'(cfg_word_r[`CWRD_WDOG_HI:`CWRD_WDOG_LO]);
    cfg_r.brownout_enable_field =
      cwrd_policy_t'(cfg_word_r[`CWRD_BROWN_HI:`CWRD_BROWN_LO]);
    cfg_r.external_clock_mode = cfg_word_r[`CWRD_CLKSEL_POS]; // R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // code protection latch; reset or a bulk erase edge clears it
  // set wins over clear so an enabled word never slips through
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cp_latch_r <= 1'b0;
      erase_d_r <= 1'b0;
    end else begin
      erase_d_r <= erase_s;
      if (cfg_loaded_r && cfg_r.code_protect) begin
        cp_latch_r <= 1'b1;
      end else if (erase_s && !erase_d_r) begin
        cp_latch_r <= 1'b0; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // policy decoders
  cwrd_policy u_wdog_pol (
    .policy_in(cfg_r.watchdog_enable_field),
    .sleep_in(sleep_s),
    .soft_en_in(wdog_ctrl_r[`CWRD_WDOG_SOFT_POS]),
    .enable_out(wdog_en_w)
  );
  cwrd_policy u_bor_pol (
    .policy_in(cfg_r.brownout_enable_field),
    .sleep_in(sleep_s),
    .soft_en_in(bor_ctrl_r[`CWRD_BROWN_SOFT_POS]),
    .enable_out(bor_en_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered enables; nothing is driven before the snapshot exists
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_out <= '0;
    end else if (cfg_loaded_r) begin
      en_out.powerup_timer <= cfg_r.powerup_timer_en; // R1 R9
      en_out.watchdog_timer <= wdog_en_w; // R2 R3 R4
      en_out.brownout_reset <= bor_en_w; // R5 R6 R7
      en_out.external_clock_mode <= cfg_r.external_clock_mode; // R8
      en_out.clock_in_pin_gpio <= ~cfg_r.external_clock_mode; // R8
      en_out.code_protect <= cp_latch_r | cfg_r.code_protect; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, ack drops after one cycle
  assign wb_req_w = wb_cyc_in & wb_stb_in & ~wb_ack_out;

  // software enable registers; writes need the low byte lane
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdog_ctrl_r <= `CWRD_WDOG_CTRL_RST;
      bor_ctrl_r <= `CWRD_BOR_CTRL_RST;
    end else if (wb_req_w && wb_we_in && wb_sel_in[0]) begin
      if (wb_adr_in == `CWRD_WDOG_CTRL_ADDR) begin
        wdog_ctrl_r <= {7'h00, wb_dat_in[`CWRD_WDOG_SOFT_POS]}; // R4
      end else if (wb_adr_in == `CWRD_BOR_CTRL_ADDR) begin
        bor_ctrl_r <= {wb_dat_in[`CWRD_BROWN_SOFT_POS], 7'h00}; // R7
      end
    end
  end

  // read mux; unmapped addresses read zero and still ack
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_in == `CWRD_WDOG_CTRL_ADDR) begin
      rd_nxt = {24'h000000, wdog_ctrl_r};
    end else if (wb_adr_in == `CWRD_BOR_CTRL_ADDR) begin
      rd_nxt = {24'h000000, bor_ctrl_r};
    end else if (wb_adr_in == `CWRD_CFG_WORD_ADDR) begin
      rd_nxt = {18'h00000, cfg_word_r};
    end else if (wb_adr_in == `CWRD_STATUS_ADDR) begin
      rd_nxt = {26'h0000000, en_out};
    end
  end

  // ack and read data registered
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req_w;
      if (wb_req_w) begin
        wb_dat_out <= rd_nxt;
      end
    end
  end
endmodule : cwrd_top
`default_nettype wire

// ### tb/cwrd_top_properties.sv
// checker of the decoder enables and of the bus answers
`timescale 1ns/10ps
`default_nettype none
module cwrd_top_properties
  import cwrd_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // watched ports
  input wire logic [13:0] cfg_word_in,
  input wire logic sleep_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire cwrd_en_t en_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [1:0] age_r; // edges since release, saturates
  logic [13:0] cap_r; // word as it was captured
  wire ok; // enables are valid from here on
  assign ok = (age_r == 2'h3);
  ////////////////////////////////////////////////////////////
  // mirror the capture edge so checks hold across a mid-run reset
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      age_r <= 2'h0;
      cap_r <= 14'h3fff;
    end else begin
      if (!ok) age_r <= age_r + 2'h1;
      if (age_r == 2'h0) cap_r <= cfg_word_in;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack stood longer than one cycle");
  property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered in one cycle");
  property p_pup; ok |-> en_out.powerup_timer == !cap_r[5]; endproperty
  a_pup: assert property (p_pup)
    else $error("power-up timer enable wrong");
  property p_clk; ok |-> en_out.external_clock_mode == cap_r[0]
    && en_out.clock_in_pin_gpio == !cap_r[0]; endproperty
  a_clk: assert property (p_clk)
    else $error("clock source wrong");
  property p_wdog_fix; ok && cap_r[4] == cap_r[3]
    |-> en_out.watchdog_timer == cap_r[4]; endproperty
  a_wdog_fix: assert property (p_wdog_fix)
    else $error("fixed watchdog policy wrong");
  property p_bor_fix; ok && cap_r[2] == cap_r[1]
    |-> en_out.brownout_reset == cap_r[2]; endproperty
  a_bor_fix: assert property (p_bor_fix)
    else $error("fixed brown-out policy wrong");
  property p_wdog_run; (ok && cap_r[4:3] == 2'h2 && sleep_in) [*8]
    |-> !en_out.watchdog_timer; endproperty
  a_wdog_run: assert property (p_wdog_run)
    else $error("watchdog kept running in sleep");
  property p_bor_run; (ok && cap_r[2:1] == 2'h2 && !sleep_in) [*8]
    |-> en_out.brownout_reset; endproperty
  a_bor_run: assert property (p_bor_run)
    else $error("brown-out off while running");
  property p_cp; ok && !cap_r[7] |-> en_out.code_protect; endproperty
  a_cp: assert property (p_cp)
    else $error("code protect dropped");
endmodule : cwrd_top_properties
bind cwrd_top cwrd_top_properties u_props (.mclk_in(mclk_in),
  .rst_b_in(rst_b_in), .cfg_word_in(cfg_word_in), .sleep_in(sleep_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
  .en_out(en_out));
`default_nettype wire

// ### tb/test_cwrd_top.sv
// self-checking bench of the configuration word decoder
`timescale 1ns/10ps
`default_nettype none
`include "cwrd_params.svh"
module test_cwrd_top;
  import cwrd_pkg::*;
  logic mclk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [13:0] cfg_word_in = 14'h3fff; // protection off from the start
  logic sleep_in = 1'h0, bulk_erase_in = 1'h0;
  logic wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0, wb_ack_out;
  logic [9:0] wb_adr_in = 10'h000;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  cwrd_en_t en_out;
  logic [13:0] c; // word of the current run
  int bad_count = 0, total_checks = 0, ticks = 0;
  always #2 mclk_in = ~mclk_in;
  cwrd_top dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .cfg_word_in(cfg_word_in), .sleep_in(sleep_in),
    .bulk_erase_in(bulk_erase_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .en_out(en_out));
  ////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // hang guard, far above the roughly 1100 cycles needed
  always @(posedge mclk_in) begin
    ticks++;
    if (ticks == 8000) begin
      bad_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge mclk_in);
    wb_cyc_in <= 1'h1;
    wb_stb_in <= 1'h1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= s;
    // no cycle count assumed; the wait ends when ack is seen, else the hang guard ends it
    do begin
      @(posedge mclk_in);
    end while (wb_ack_out !== 1'h1);
    q = wb_dat_out;
    wb_cyc_in <= 1'h0;
    wb_stb_in <= 1'h0;
    wb_we_in <= 1'h0;
  endtask : wb
  // expected enables: policy, sleep, soft bit
  function automatic logic pol(logic [1:0] p, logic s, logic sw);
    return p == 2'h3 || (p == 2'h2 && !s) || (p == 2'h1 && sw);
  endfunction : pol
  function automatic logic [31:0] ex(logic [13:0] k, logic s, logic sw,
    logic sb);
    return {26'h0, !k[5], pol(k[4:3], s, sw), pol(k[2:1], s, sb), k[0],
      !k[0], !k[7]};
  endfunction : ex
  // reset with a new word, soft bits at their reset values
  task run(input logic [13:0] k);
    c = k;
    cfg_word_in <= k;
    rst_b_in <= 1'h0;
    @(posedge mclk_in);
    rst_b_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    chk(32'(en_out), ex(k, 1'h0, 1'h0, 1'h1));
  endtask : run
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_in);
    // every policy pair, power-up and clock bits varied
    for (int i = 0; i < 32; i++) begin
      run({8'hff, i[4:0], i[0] ^ i[2]});
      wb(1'h0, `CWRD_WDOG_CTRL_ADDR, 32'h0, 4'hf);
      chk(q, 32'h00);
      wb(1'h0, `CWRD_BOR_CTRL_ADDR, 32'h0, 4'hf);
      chk(q, 32'h80);
      wb(1'h1, `CWRD_WDOG_CTRL_ADDR, 32'h1, 4'h1);
      wb(1'h1, `CWRD_BOR_CTRL_ADDR, 32'h0, 4'h1);
      repeat (2) @(posedge mclk_in);
      chk(32'(en_out), ex(c, 1'h0, 1'h1, 1'h0));
      cfg_word_in <= c ^ 14'h007f; // a late change must not count
      sleep_in <= 1'h1;
      repeat (8) @(posedge mclk_in);
      chk(32'(en_out), ex(c, 1'h1, 1'h1, 1'h0));
      sleep_in <= 1'h0;
      cfg_word_in <= c;
      repeat (8) @(posedge mclk_in);
      chk(32'(en_out), ex(c, 1'h0, 1'h1, 1'h0));
    end
    // unmapped read, read-only word
    wb(1'h0, 10'h200, 32'h0, 4'hf);
    chk(q, 32'h0);
    wb(1'h1, `CWRD_CFG_WORD_ADDR, 32'h0, 4'hf);
    wb(1'h0, `CWRD_CFG_WORD_ADDR, 32'h0, 4'hf);
    chk(q, {18'h0, c});
    // lane 0 off: write ignored
    run(14'h3fca);
    wb(1'h1, `CWRD_WDOG_CTRL_ADDR, 32'h1, 4'he);
    wb(1'h0, `CWRD_WDOG_CTRL_ADDR, 32'h0, 4'hf);
    chk(q, 32'h0);
    chk(32'(en_out), ex(c, 1'h0, 1'h0, 1'h1));
    // protection survives writes and an erase while still enabled
    run(14'h3f7f);
    wb(1'h1, `CWRD_CFG_WORD_ADDR, 32'h3fff, 4'hf);
    bulk_erase_in <= 1'h1;
    repeat (6) @(posedge mclk_in);
    bulk_erase_in <= 1'h0;
    repeat (6) @(posedge mclk_in);
    chk(32'(en_out), ex(c, 1'h0, 1'h0, 1'h1));
    wrap_up();
  end
endmodule : test_cwrd_top
`default_nettype wire
